// [design/clock_gen_test_status_slew_regs.v]
`include "clock_gen_map.vh"

module clock_gen_test_status_slew_regs (
    input  wire       clk,
    input  wire       rstn,
    input  wire       smb_clk,
    input  wire       smb_data_in,
    output wire       smb_data_out,
    output reg        smb_data_oe,
    input  wire       ref_clk_in,
    input  wire       cpu_pll_lock,
    input  wire       video_pll_lock_flag,
    input  wire       fixed_pll_lock,
    input  wire       serial_ref_pll_lock_flag,
    input  wire       freq_accurate,
    input  wire       rails_valid,
    input  wire       clock_power_good_input,
    input  wire       crystal_detected,
    output wire       test_mode_active,
    output wire       test_clock_out,
    output wire       diag_mode_out,
    output wire [1:0] ref_out0_slew,
    output wire [1:0] ref_out1_slew,
    output wire [1:0] ref_out2_slew,
    output wire [1:0] usb_clock_slew,
    output reg  [3:0] se_output_enable
);

    localparam ST_IDLE  = 3'h0;
    localparam ST_ADDR  = 3'h1;
    localparam ST_CMD   = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_ACK   = 3'h4;
    localparam ST_RDATA = 3'h5;
    localparam ST_RACK  = 3'h6;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg  [8:0] sync1_reg;
    reg  [8:0] sync2_reg;
    reg        scl_prev_reg;
    reg        sda_prev_reg;
    wire       scl_s;
    wire       sda_s;
    wire       ref_s;

    always @(posedge clk) begin
        if (!rstn) begin
            sync1_reg    <= 9'h003;
            sync2_reg    <= 9'h003;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            sync1_reg    <= {ref_clk_in, cpu_pll_lock, video_pll_lock_flag, fixed_pll_lock,
                             serial_ref_pll_lock_flag, freq_accurate,
                             rails_valid & clock_power_good_input & crystal_detected,
                             smb_clk, smb_data_in};
            sync2_reg    <= sync1_reg;
            scl_prev_reg <= sync2_reg[1];
            sda_prev_reg <= sync2_reg[0];
        end
    end

    assign scl_s = sync2_reg[1];
    assign sda_s = sync2_reg[0];
    assign ref_s = sync2_reg[8];

    wire scl_rise = scl_s & ~scl_prev_reg;
    wire scl_fall = ~scl_s & scl_prev_reg;
    wire start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    wire stop_cond  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [1:0] test_cfg_reg;
    reg  [5:0] status_reg;
    reg  [7:0] slew_reg;
    wire [7:0] test_cfg_read;
    reg        wr_en;
    reg  [7:0] wr_addr;
    reg  [7:0] wr_data;

    assign test_cfg_read = {test_cfg_reg, status_reg};

    always @(posedge clk) begin
        if (!rstn) begin
            test_cfg_reg <= `TEST_CFG_RESET;
            status_reg   <= 6'h00;
            slew_reg     <= `SLEW_SEL_RESET;
        end else begin
            // status follows live hardware, never the host
            status_reg <= sync2_reg[7:2];
            if (wr_en && wr_addr == `TEST_CFG_OFFSET) begin
                test_cfg_reg <= wr_data[`TEST_MODE_BIT:`DIAGNOSTIC_ENABLE_BIT];
            end else if (wr_en && wr_addr == `SLEW_SEL_OFFSET) begin
                slew_reg <= wr_data;
            end
        end
    end

    function [7:0] read_byte;
        input [7:0] addr;
        begin
            if (addr == `TEST_CFG_OFFSET) begin
                read_byte = test_cfg_read;
            end else if (addr == `SLEW_SEL_OFFSET) begin
                read_byte = slew_reg;
            end else begin
                read_byte = `UNMAPPED_READ;
            end
        end
    endfunction

    // ----------------------------------------
    // serial bus slave
    // ----------------------------------------
    reg  [2:0] state_reg;
    reg  [2:0] ack_next_reg;
    reg  [3:0] bit_cnt_reg;
    reg  [7:0] shift_reg;
    reg  [7:0] tx_reg;
    reg  [7:0] ptr_reg;
    reg        master_ack_reg;
    wire [7:0] rd_byte;

    // byte at the pointer, loaded into the shifter at the start of each read byte
    assign rd_byte      = read_byte(ptr_reg);
    assign smb_data_out = 1'b0;

    always @(posedge clk) begin
        if (!rstn) begin
            state_reg      <= ST_IDLE;
            ack_next_reg   <= ST_IDLE;
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= 8'h00;
            tx_reg         <= 8'h00;
            ptr_reg        <= 8'h00;
            master_ack_reg <= 1'b0;
            smb_data_oe    <= 1'b0;
            wr_en          <= 1'b0;
            wr_addr        <= 8'h00;
            wr_data        <= 8'h00;
        end else begin
            wr_en <= 1'b0;
            if (start_cond) begin
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                smb_data_oe <= 1'b0;
            end else if (stop_cond) begin
                state_reg   <= ST_IDLE;
                smb_data_oe <= 1'b0;
            end else if (scl_rise) begin
                if (state_reg == ST_ADDR || state_reg == ST_CMD || state_reg == ST_WDATA) begin
                    shift_reg   <= {shift_reg[6:0], sda_s};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end else if (state_reg == ST_RACK) begin
                    master_ack_reg <= ~sda_s;
                end
            end else if (scl_fall) begin
                case (state_reg)
                    ST_ADDR: begin
                        if (bit_cnt_reg == `BITS_PER_BYTE) begin
                            if (shift_reg[7:1] == `SLAVE_ADDR) begin
                                smb_data_oe  <= 1'b1;
                                state_reg    <= ST_ACK;
                                ack_next_reg <= shift_reg[0] ? ST_RDATA : ST_CMD;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_CMD: begin
                        if (bit_cnt_reg == `BITS_PER_BYTE) begin
                            ptr_reg      <= shift_reg;
                            smb_data_oe  <= 1'b1;
                            state_reg    <= ST_ACK;
                            ack_next_reg <= ST_WDATA;
                        end
                    end
                    ST_WDATA: begin
                        if (bit_cnt_reg == `BITS_PER_BYTE) begin
                            wr_en        <= 1'b1;
                            wr_addr      <= ptr_reg;
                            wr_data      <= shift_reg;
                            ptr_reg      <= ptr_reg + 8'h01;
                            smb_data_oe  <= 1'b1;
                            state_reg    <= ST_ACK;
                            ack_next_reg <= ST_WDATA;
                        end
                    end
                    ST_ACK: begin
                        bit_cnt_reg <= 4'h0;
                        if (ack_next_reg == ST_RDATA) begin
                            // first bit goes out on the same falling edge that ends the ack
                            tx_reg      <= {rd_byte[6:0], 1'b0};
                            smb_data_oe <= ~rd_byte[7];
                            ptr_reg     <= ptr_reg + 8'h01;
                            bit_cnt_reg <= 4'h1;
                        end else begin
                            smb_data_oe <= 1'b0;
                        end
                        state_reg <= ack_next_reg;
                    end
                    ST_RDATA: begin
                        if (bit_cnt_reg == `BITS_PER_BYTE) begin
                            smb_data_oe <= 1'b0;
                            state_reg   <= ST_RACK;
                        end else begin
                            smb_data_oe <= ~tx_reg[7];
                            tx_reg      <= {tx_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                    ST_RACK: begin
                        if (master_ack_reg) begin
                            tx_reg      <= {rd_byte[6:0], 1'b0};
                            smb_data_oe <= ~rd_byte[7];
                            ptr_reg     <= ptr_reg + 8'h01;
                            bit_cnt_reg <= 4'h1;
                            state_reg   <= ST_RDATA;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // test mode and diagnostic outputs
    // ----------------------------------------
    assign test_mode_active = test_cfg_reg[1];
    assign diag_mode_out    = test_cfg_reg[0];

    ref_divider u_ref_divider (
        .clk       (clk),
        .rstn      (rstn),
        .enable    (test_cfg_reg[1]),
        .ref_level (ref_s),
        .div_clk   (test_clock_out)
    );

    // ----------------------------------------
    // single-ended output slew and enable
    // ----------------------------------------
    assign ref_out0_slew  = slew_reg[1:0];
    assign ref_out1_slew  = slew_reg[3:2];
    assign ref_out2_slew  = slew_reg[5:4];
    assign usb_clock_slew = slew_reg[7:6];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_se
            always @(posedge clk) begin
                if (!rstn) begin
                    se_output_enable[gi] <= 1'b1;
                end else begin
                    // code 00 floats the output
                    se_output_enable[gi] <= (slew_reg[2*gi+1:2*gi] != `SLEW_TRISTATE);
                end
            end
        end
    endgenerate

endmodule

// [design/clock_gen_map.vh]
`ifndef CLOCK_GEN_MAP_VH
`define CLOCK_GEN_MAP_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define TEST_CFG_OFFSET   8'h18
`define SLEW_SEL_OFFSET   8'h19
`define TEST_MODE_BIT     7
`define DIAGNOSTIC_ENABLE_BIT   6
`define TEST_CFG_RESET    2'h0
`define SLEW_SEL_RESET    8'hff
`define UNMAPPED_READ     8'h00

// ----------------------------------------
// slew codes
// ----------------------------------------
`define SLEW_FAST         2'h3
`define SLEW_MEDIUM       2'h2
`define SLEW_SLOW         2'h1
`define SLEW_TRISTATE     2'h0

// ----------------------------------------
// serial bus and test divider
// ----------------------------------------
`define SLAVE_ADDR        7'h50
`define REF_DIV_N         8'h04
`define BITS_PER_BYTE     4'h8

`endif

// [design/ref_divider.v]
`include "clock_gen_map.vh"

module ref_divider (
    input  wire       clk,
    input  wire       rstn,
    input  wire       enable,
    input  wire       ref_level,
    output reg        div_clk
);

    reg        ref_prev_reg;
    reg  [7:0] edge_cnt_reg;
    wire       ref_rise;

    assign ref_rise = ref_level & ~ref_prev_reg;

    // ----------------------------------------
    // divide by N, toggling every N/2 reference edges
    // ----------------------------------------
    // odd N rounds the half period down; only even N gives exact ratio
    always @(posedge clk) begin
        if (!rstn) begin
            ref_prev_reg <= 1'b0;
            edge_cnt_reg <= 8'h00;
            div_clk      <= 1'b0;
        end else begin
            ref_prev_reg <= ref_level;
            if (!enable) begin
                edge_cnt_reg <= 8'h00;
                div_clk      <= 1'b0;
            end else if (ref_rise) begin
                if (edge_cnt_reg >= ((`REF_DIV_N >> 1) - 8'h01)) begin
                    edge_cnt_reg <= 8'h00;
                    div_clk      <= ~div_clk;
                end else begin
                    edge_cnt_reg <= edge_cnt_reg + 8'h01;
                end
            end
        end
    end

endmodule

// [test/smb_host_model.sv]
`include "clock_gen_map.vh"

module smb_host_model (
    input  wire  clk,
    input  wire  dev_oe,
    output logic scl,
    output wire  sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pull_low = 1'b0;
    // ----------------------------------------
    // open-drain wire with pull-up
    // ----------------------------------------
    assign sda = ~(pull_low | dev_oe);
    initial scl = 1'b1;
    task automatic hw(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic bitx(input logic b, output logic r);
        pull_low = ~b;
        hw(5);
        scl = 1'b1;
        hw(10);
        r = sda;
        scl = 1'b0;
        hw(5);
    endtask
    task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(m, a);
    endtask
    // also serves as repeated start from scl low
    task automatic start;
        pull_low = 1'b0;
        hw(5);
        scl = 1'b1;
        hw(5);
        pull_low = 1'b1;
        hw(5);
        scl = 1'b0;
    endtask
    task automatic stop;
        pull_low = 1'b1;
        hw(5);
        scl = 1'b1;
        hw(5);
        pull_low = 1'b0;
        hw(10);
    endtask
    task automatic wr(input logic [6:0] ad, input logic [7:0] off, input logic [7:0] d, output logic nak);
        logic [7:0] q;
        logic       a0;
        logic       a1;
        logic       a2;
        start;
        byte_x({ad, 1'b0}, 1'b1, q, a0);
        byte_x(off, 1'b1, q, a1);
        byte_x(d, 1'b1, q, a2);
        stop;
        nak = a0 | a1 | a2;
    endtask
    // last byte is nacked, so reads are single byte
    task automatic rd(input logic [7:0] off, output logic [7:0] d);
        logic [7:0] q;
        logic       a;
        start;
        byte_x({`SLAVE_ADDR, 1'b0}, 1'b1, q, a);
        byte_x(off, 1'b1, q, a);
        start;
        byte_x({`SLAVE_ADDR, 1'b1}, 1'b1, q, a);
        byte_x(8'hff, 1'b1, d, a);
        stop;
    endtask
endmodule

// [test/clock_gen_test_status_slew_regs_assertions.sv]
module clock_gen_checker (
    input wire       clk,
    input wire       rstn,
    input wire       smb_clk,
    input wire       smb_data_oe,
    input wire       test_mode_active,
    input wire       test_clock_out,
    input wire       diag_mode_out,
    input wire [1:0] ref_out0_slew,
    input wire [1:0] ref_out1_slew,
    input wire [1:0] ref_out2_slew,
    input wire [1:0] usb_clock_slew,
    input wire [3:0] se_output_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire [7:0] slew = {usb_clock_slew, ref_out2_slew, ref_out1_slew, ref_out0_slew};
    sequence oe_held;
        smb_data_oe [*8];
    endsequence
    sequence div_high;
        (test_clock_out || !test_mode_active) [*8];
    endsequence
    property p_reset;
        @(posedge clk) disable iff (1'b0) !rstn |=> !test_mode_active && !diag_mode_out && slew == 8'hff;
    endproperty
    a_reset_state: assert property (p_reset)
        else $error("outputs wrong after reset");
    a_idle_clock_low: assert property (!test_mode_active && !$past(test_mode_active) |-> !test_clock_out)
        else $error("test clock runs outside test mode");
    a_div_high_time: assert property ($rose(test_clock_out) |=> div_high)
        else $error("test clock high too short");
    a_slew_enable: assert property (se_output_enable == {|$past(usb_clock_slew), |$past(ref_out2_slew),
        |$past(ref_out1_slew), |$past(ref_out0_slew)})
        else $error("output enable disagrees with slew");
    a_slew_scl_low: assert property ($changed(slew) |-> !smb_clk)
        else $error("slew changed outside a bus write");
    a_cfg_scl_low: assert property ($changed({test_mode_active, diag_mode_out}) |-> !smb_clk)
        else $error("config changed outside a bus write");
    a_oe_scl_low: assert property ($changed(smb_data_oe) |-> !smb_clk)
        else $error("data drive changed with bus clock high");
    a_ack_held: assert property ($rose(smb_data_oe) |=> oe_held)
        else $error("data drive released too early");
endmodule

bind clock_gen_test_status_slew_regs clock_gen_checker u_clock_gen_checker (.*);

// [test/tb.sv]
`include "clock_gen_map.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk;
    logic       rstn;
    logic       ref_clk_in = 1'b0;
    logic [7:0] pins;
    wire        smb_clk;
    wire        smb_data;
    wire        smb_data_oe;
    wire        smb_data_out;
    wire        test_mode_active;
    wire        test_clock_out;
    wire        diag_mode_out;
    wire  [1:0] ref_out0_slew;
    wire  [1:0] ref_out1_slew;
    wire  [1:0] ref_out2_slew;
    wire  [1:0] usb_clock_slew;
    wire  [3:0] se_output_enable;
    int         num_errors = 0;
    int         n_compared = 0;
    int         n;
    logic [7:0] q;
    logic [7:0] d;
    logic       nak;
    logic [7:0] tbl [3] = '{8'h00, 8'h1b, 8'he4};
    clock_gen_test_status_slew_regs u_clock_gen_test_status_slew_regs (
        .smb_data_in(smb_data), .smb_data_out(smb_data_out), .cpu_pll_lock(pins[7]), .video_pll_lock_flag(pins[6]),
        .fixed_pll_lock(pins[5]), .serial_ref_pll_lock_flag(pins[4]), .freq_accurate(pins[3]),
        .rails_valid(pins[2]), .clock_power_good_input(pins[1]), .crystal_detected(pins[0]), .*);
    smb_host_model u_smb_host_model (.clk(clk), .dev_oe(smb_data_oe), .scl(smb_clk), .sda(smb_data));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // reference period of 12 clocks
    always begin
        repeat (6) @(negedge clk);
        ref_clk_in = ~ref_clk_in;
    end
    function automatic logic [7:0] exp_cfg(input logic tm, input logic dg, input logic [7:0] p);
        return {tm, dg, p[7:3], &p[2:0]};
    endfunction
    function automatic logic [7:0] exp_oe(input logic [7:0] s);
        return {4'h0, |s[7:6], |s[5:4], |s[3:2], |s[1:0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic do_reset;
        @(negedge clk);
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    task automatic next_rise;
        n = 0;
        while (test_clock_out === 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        while (test_clock_out !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            end_of_test;
        end
    endtask
    initial begin
        rstn = 1'b0;
        pins = 8'h00;
        void'($urandom(66));
        do_reset;
        u_smb_host_model.rd(`SLEW_SEL_OFFSET, q);
        chk("slew after reset", q, `SLEW_SEL_RESET);
        for (int i = 0; i < 6; i++) begin
            pins = (i == 0) ? 8'hff : (i == 1) ? 8'h07 : 8'($urandom);
            d = (i < 2) ? {i[0], 7'h7f} : 8'($urandom);
            u_smb_host_model.wr(`SLAVE_ADDR, `TEST_CFG_OFFSET, d, nak);
            chk("config ack", {7'h0, nak}, 8'h00);
            u_smb_host_model.rd(`TEST_CFG_OFFSET, q);
            chk("config readback", q, exp_cfg(d[7], d[6], pins));
            chk("test mode", {7'h0, test_mode_active}, {7'h0, d[7]});
            chk("diag mode", {7'h0, diag_mode_out}, {7'h0, d[6]});
            if (d[7] === 1'b1) begin
                next_rise;
                next_rise;
                chk("test clock period", n[7:0], `REF_DIV_N * 8'd12);
            end
        end
        for (int i = 0; i < 6; i++) begin
            d = (i < 3) ? tbl[i] : 8'($urandom);
            u_smb_host_model.wr(`SLAVE_ADDR, `SLEW_SEL_OFFSET, d, nak);
            chk("slew ack", {7'h0, nak}, 8'h00);
            chk("slew pins", {usb_clock_slew, ref_out2_slew, ref_out1_slew, ref_out0_slew}, d);
            chk("output enable", {4'h0, se_output_enable}, exp_oe(d));
            u_smb_host_model.rd(`SLEW_SEL_OFFSET, q);
            chk("slew readback", q, d);
        end
        u_smb_host_model.wr(`SLAVE_ADDR ^ 7'h01, `SLEW_SEL_OFFSET, 8'hff, nak);
        chk("foreign address nack", {7'h0, nak}, 8'h01);
        chk("data out level", {7'h0, smb_data_out}, 8'h00);
        u_smb_host_model.rd(8'h30, q);
        chk("unmapped read", q, `UNMAPPED_READ);
        u_smb_host_model.wr(`SLAVE_ADDR, `TEST_CFG_OFFSET, 8'hc0, nak);
        do_reset;
        u_smb_host_model.rd(`TEST_CFG_OFFSET, q);
        chk("config after reset", q, exp_cfg(1'b0, 1'b0, pins));
        u_smb_host_model.rd(`SLEW_SEL_OFFSET, q);
        chk("slew after reset", q, `SLEW_SEL_RESET);
        end_of_test;
    end
endmodule
